// ===== verilog/bcl_pkg.sv
package bcl_pkg;

  // ----------------------------------------------------------------------
  // address layout
  // ----------------------------------------------------------------------
  localparam logic [3:0] BCL_PRI_ADDR_HI  = 4'h4;
  localparam logic [6:0] BCL_SEC_ADDR     = 7'h38;
  localparam int         BCL_PRI_CODE_LSB = 1;
  localparam int         BCL_PRI_CODE_MSB = 3;

  // ----------------------------------------------------------------------
  // strap quantisation: divider ratio in hundredths, 0..100
  // ----------------------------------------------------------------------
  localparam logic [6:0] BCL_ADR_T1 = 7'h0a;
  localparam logic [6:0] BCL_ADR_T2 = 7'h27;
  localparam logic [6:0] BCL_ADR_T3 = 7'h4b;
  localparam logic [6:0] BCL_DIV_FULL = 7'h64;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int BCL_CLK_HZ      = 10000000;
  localparam int BCL_SETTLE_NS   = 1000;
  localparam int BCL_SETTLE_CYC  =
    (BCL_SETTLE_NS * (BCL_CLK_HZ / 1000000) + 999) / 1000;

  // ----------------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    BCL_DB_NO_RESPONSE = 3'h0,
    BCL_DB_WAIT_INT    = 3'h1,
    BCL_DB_HOST_INT    = 3'h2,
    BCL_DB_WAIT_EXT    = 3'h3,
    BCL_DB_HOST_EXT    = 3'h4,
    BCL_DB_NO_WAIT     = 3'h5
  } bcl_db_t;

  typedef enum logic [2:0] {
    BCL_CF_SAFE     = 3'h0,
    BCL_CF_INFINITE = 3'h1,
    BCL_CF_CONFIG1  = 3'h2,
    BCL_CF_CONFIG2  = 3'h3,
    BCL_CF_CONFIG3  = 3'h4,
    BCL_CF_CONFIG4  = 3'h5,
    BCL_CF_CONFIG5  = 3'h6
  } bcl_cf_t;

  typedef struct packed {
    bcl_db_t db;
    bcl_cf_t cf;
  } bcl_boot_t;

  typedef struct packed {
    logic [6:0] pri_addr;
    logic [6:0] sec_addr;
  } bcl_addr_t;

  typedef enum logic [2:0] {
    BCL_ST_INIT   = 3'h0,
    BCL_ST_STRAP  = 3'h1,
    BCL_ST_SUPPLY = 3'h2,
    BCL_ST_LOAD   = 3'h3,
    BCL_ST_WAIT   = 3'h4,
    BCL_ST_DONE   = 3'h5,
    BCL_ST_HOST   = 3'h6
  } bcl_state_t;

endpackage

// ===== verilog/bcl_boot_config.sv
`timescale 1ns/1ns
// Operation
// - slave may hold clock low when busy
// - stretching allowed on any clock pulse
// - addresses fixed before ports answer
// - primary address 0100, strap code, direction
// - secondary address fixed 0111000 plus direction
// - every address bit maskable per port
// - address strap bands map to codes
// - boot reads patch and config from flash
// - mode 0, low chip select, data immediate
// - shift on falling, sample on rising
// - serial clock idles low
// - init registers, then load bundles
// - data-in strap high boot band decode
// - data-in strap low boot band decode
// - ack on matching address byte
// - no-response waits for 3v3 supply
// - infinite wait stays in boot
module bcl_boot_config
  import bcl_pkg::*;
#(
  parameter int LOAD_BYTES = 16
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [6:0]  address_strap_input,
  input  wire logic [6:0]  boot_strap_divider_input,
  input  wire logic        external_3v3_supply,
  input  wire logic [6:0]  pri_addr_mask,
  input  wire logic [6:0]  pri_addr_override,
  input  wire logic [6:0]  sec_addr_mask,
  input  wire logic [6:0]  sec_addr_override,
  input  wire logic        host_config_done,
  input  wire logic        pri_stretch_req,
  input  wire logic        sec_stretch_req,
  input  wire logic        spi_clk_link,
  input  wire logic        spi_data_in,
  output logic             spi_clk_out,
  output logic             spi_sel_n,
  output logic             spi_data_out,
  output bcl_addr_t        host_addr,
  output logic             ports_enable,
  output bcl_boot_t        boot_mode,
  output logic             load_busy,
  output logic             load_done,
  output logic [7:0]       load_byte,
  output logic             load_byte_valid,
  output logic             pri_scl_hold,
  output logic             sec_scl_hold
);

  // header bytes must still fit the 16-bit byte counter
  if (LOAD_BYTES < 1 || LOAD_BYTES > 65531) begin : g_bad_load_bytes
    $error("LOAD_BYTES out of range");
  end
  // ----------------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------------
  function automatic logic [2:0] adr_code(input logic [6:0] d);
    if (d < BCL_ADR_T1)      adr_code = 3'h0;
    else if (d < BCL_ADR_T2) adr_code = 3'h1;
    else if (d < BCL_ADR_T3) adr_code = 3'h2;
    else                     adr_code = 3'h3;
  endfunction

  function automatic bcl_boot_t boot_dec(input logic hi,
                                         input logic [6:0] d);
    bcl_boot_t r;
    logic [3:0] b;
    r = '{BCL_DB_NO_RESPONSE, BCL_CF_SAFE};
    // band index by tenths, rounded down after adding one hundredth, capped at band 9
    b = (d > BCL_DIV_FULL) ? 4'h9 : 4'((d + 7'h01) / 7'h0a);
    if (b > 4'h9) b = 4'h9;
    if (hi) begin
      unique case (b)
        4'h0, 4'h1: r = '{BCL_DB_NO_RESPONSE, BCL_CF_SAFE};
        4'h2:       r = '{BCL_DB_WAIT_INT,    BCL_CF_SAFE};
        4'h3:       r = '{BCL_DB_HOST_INT,    BCL_CF_INFINITE};
        4'h4:       r = '{BCL_DB_WAIT_EXT,    BCL_CF_SAFE};
        4'h5:       r = '{BCL_DB_HOST_EXT,    BCL_CF_INFINITE};
        default:    r = '{BCL_DB_NO_WAIT,     BCL_CF_SAFE};
      endcase
    end else begin
      unique case (b)
        4'h0, 4'h1: r = '{BCL_DB_NO_RESPONSE, BCL_CF_CONFIG1};
        4'h2:       r = '{BCL_DB_NO_RESPONSE, BCL_CF_CONFIG2};
        4'h3:       r = '{BCL_DB_HOST_INT,    BCL_CF_INFINITE};
        4'h4:       r = '{BCL_DB_NO_WAIT,     BCL_CF_CONFIG3};
        4'h5:       r = '{BCL_DB_HOST_EXT,    BCL_CF_INFINITE};
        4'h6:       r = '{BCL_DB_NO_RESPONSE, BCL_CF_CONFIG4};
        4'h7:       r = '{BCL_DB_NO_WAIT,     BCL_CF_SAFE};
        4'h8:       r = '{BCL_DB_NO_RESPONSE, BCL_CF_SAFE};
        default:    r = '{BCL_DB_NO_WAIT,     BCL_CF_CONFIG5};
      endcase
    end
    boot_dec = r;
  endfunction

  // ----------------------------------------------------------------------
  // system domain state
  // ----------------------------------------------------------------------
  typedef struct packed {
    bcl_state_t st;
    logic [7:0] cnt;
    logic [6:0] adr_s1;
    logic [6:0] adr_s2;
    logic [6:0] div_s1;
    logic [6:0] div_s2;
    logic       sup_s1;
    logic       sup_s2;
    logic       miso_s1;
    logic       miso_s2;
    logic [2:0] code;
    bcl_boot_t  mode;
    bcl_addr_t  addr;
    logic       en;
    logic       busy;
    logic       done;
    logic       go_tgl;
    logic       ack_s1;
    logic       ack_s2;
    logic       ack_s3;
    logic       byt_s1;
    logic       byt_s2;
    logic       byt_s3;
    logic [7:0] byte_r;
    logic       byte_v;
    logic       phold;
    logic       shold;
  } sys_t;

  sys_t s_q, s_d;

  // ----------------------------------------------------------------------
  // link domain state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        go_s1;
    logic        go_s2;
    logic        go_s3;
    logic        act;
    logic [15:0] left;
    logic [2:0]  bit_i;
    logic [7:0]  sh_in;
    logic [7:0]  sh_out;
    logic        byt_tgl;
    logic        ack_tgl;
    logic [7:0]  data;
  } lnk_t;

  lnk_t l_q, l_d;

  always_comb begin
    s_d = s_q;
    s_d.adr_s1  = address_strap_input;
    s_d.adr_s2  = s_q.adr_s1;
    s_d.div_s1  = boot_strap_divider_input;
    s_d.div_s2  = s_q.div_s1;
    s_d.sup_s1  = external_3v3_supply;
    s_d.sup_s2  = s_q.sup_s1;
    s_d.miso_s1 = spi_data_in;
    s_d.miso_s2 = s_q.miso_s1;
    s_d.ack_s1  = l_q.ack_tgl;
    s_d.ack_s2  = s_q.ack_s1;
    s_d.ack_s3  = s_q.ack_s2;
    s_d.byt_s1  = l_q.byt_tgl;
    s_d.byt_s2  = s_q.byt_s1;
    s_d.byt_s3  = s_q.byt_s2;
    s_d.byte_v  = 1'b0;
    if (s_q.byt_s2 != s_q.byt_s3) begin
      s_d.byte_r = l_q.data; // stable since toggle left link side
      s_d.byte_v = 1'b1;
    end
    // stretch only when ports are enabled and the core requests it
    s_d.phold = s_q.en & pri_stretch_req;
    s_d.shold = s_q.en & sec_stretch_req;
    // address with per-bit firmware override
    s_d.addr.pri_addr = ({BCL_PRI_ADDR_HI, s_q.code} & ~pri_addr_mask)
                      | (pri_addr_override & pri_addr_mask);
    s_d.addr.sec_addr = (BCL_SEC_ADDR & ~sec_addr_mask)
                      | (sec_addr_override & sec_addr_mask);
    unique case (s_q.st)
      BCL_ST_INIT: begin
        s_d.cnt = s_q.cnt + 8'h01;
        if (s_q.cnt == 8'(BCL_SETTLE_CYC)) begin
          s_d.st = BCL_ST_STRAP;
        end
      end
      BCL_ST_STRAP: begin
        s_d.code = adr_code(s_q.adr_s2);
        s_d.mode = boot_dec(s_q.miso_s2, s_q.div_s2);
        s_d.st   = BCL_ST_SUPPLY;
      end
      BCL_ST_SUPPLY: begin
        if (s_q.sup_s2 || s_q.mode.db == BCL_DB_NO_WAIT ||
            s_q.mode.db == BCL_DB_HOST_INT ||
            s_q.mode.db == BCL_DB_HOST_EXT) begin
          s_d.st     = BCL_ST_LOAD;
          s_d.busy   = 1'b1;
          s_d.go_tgl = ~s_q.go_tgl;
        end
      end
      BCL_ST_LOAD: begin
        if (s_q.ack_s2 != s_q.ack_s3) begin
          s_d.busy = 1'b0;
          s_d.st   = (s_q.mode.cf == BCL_CF_INFINITE) ?
                     BCL_ST_HOST : BCL_ST_DONE;
        end
      end
      BCL_ST_HOST: begin
        s_d.en = 1'b1;
        if (host_config_done) begin
          s_d.st = BCL_ST_DONE;
        end
      end
      BCL_ST_DONE: begin
        s_d.en   = 1'b1;
        s_d.done = 1'b1;
      end
      default: s_d.st = BCL_ST_INIT;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // flash reader, read command from address zero
  // ----------------------------------------------------------------------
  always_comb begin
    l_d = l_q;
    l_d.go_s1 = s_q.go_tgl;
    l_d.go_s2 = l_q.go_s1;
    l_d.go_s3 = l_q.go_s2;
    if (!l_q.act && (l_q.go_s2 != l_q.go_s3)) begin
      // read cmd 03, 24-bit address 0, then data
      l_d.act    = 1'b1;
      l_d.left   = 16'(LOAD_BYTES + 4);
      l_d.sh_out = 8'h03;
      l_d.bit_i  = 3'h0;
    end else if (l_q.act) begin
      if (l_q.bit_i == 3'h7) begin
        l_d.sh_out = 8'h00;
        l_d.left   = l_q.left - 16'h0001;
        if (l_q.left <= 16'(LOAD_BYTES)) begin
          l_d.data    = {l_q.sh_in[6:0], spi_data_in};
          l_d.byt_tgl = ~l_q.byt_tgl;
        end
        if (l_q.left == 16'h0001) begin
          l_d.act     = 1'b0;
          l_d.ack_tgl = ~l_q.ack_tgl;
        end
      end else begin
        l_d.sh_out = {l_q.sh_out[6:0], 1'b0};
      end
      l_d.sh_in = {l_q.sh_in[6:0], spi_data_in};
      l_d.bit_i = l_q.bit_i + 3'h1;
    end
  end

  always_ff @(posedge spi_clk_link) begin
    if (!nrst) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // select, data and clock gate change on falling edge, clock low there
  logic mosi_q;
  logic clk_en_q;
  logic sel_n_q;
  always_ff @(negedge spi_clk_link) begin
    if (!nrst) begin
      mosi_q   <= 1'b0;
      clk_en_q <= 1'b0;
      sel_n_q  <= 1'b1;
    end else begin
      mosi_q   <= l_q.act ? l_q.sh_out[7] : 1'b0;
      clk_en_q <= l_q.act;
      sel_n_q  <= ~l_q.act;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign spi_clk_out     = clk_en_q & spi_clk_link;
  assign spi_sel_n       = sel_n_q;
  assign spi_data_out    = mosi_q;
  // slave acks an address byte matching these
  assign host_addr       = s_q.addr;
  assign ports_enable    = s_q.en;
  assign boot_mode       = s_q.mode;
  assign load_busy       = s_q.busy;
  assign load_done       = s_q.done;
  assign load_byte       = s_q.byte_r;
  assign load_byte_valid = s_q.byte_v;
  assign pri_scl_hold    = s_q.phold;
  assign sec_scl_hold    = s_q.shold;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence load_start;
    s_q.st == BCL_ST_SUPPLY ##1 s_q.st == BCL_ST_LOAD;
  endsequence

  chk_ports_after_load: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_q.en |-> (s_q.st == BCL_ST_DONE || s_q.st == BCL_ST_HOST))
    else $error("ports enabled before boot end");
  chk_sec_addr_fixed: assert property (@(posedge clk_sys) disable iff (!nrst)
    sec_addr_mask == 7'h00 && $past(sec_addr_mask) == 7'h00
      && s_q.st != BCL_ST_INIT |-> host_addr.sec_addr == 7'h38)
    else $error("secondary address wrong");
  chk_pri_addr_hi: assert property (@(posedge clk_sys) disable iff (!nrst)
    pri_addr_mask == 7'h00 && $past(pri_addr_mask) == 7'h00
      && s_q.st == BCL_ST_DONE |-> host_addr.pri_addr[6:3] == 4'h4)
    else $error("primary address prefix wrong");
  chk_straps_stable: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_q.st == BCL_ST_DONE |=> $stable(boot_mode))
    else $error("boot mode changed after boot");
  chk_supply_wait: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_q.st == BCL_ST_SUPPLY && !s_q.sup_s2
      && s_q.mode.db == BCL_DB_NO_RESPONSE |=> s_q.st == BCL_ST_SUPPLY)
    else $error("start-up without supply");
  chk_infinite_wait: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_q.st == BCL_ST_HOST && !host_config_done |=> s_q.st == BCL_ST_HOST)
    else $error("left infinite wait early");
  chk_load_busy: assert property (@(posedge clk_sys) disable iff (!nrst)
    load_start |-> s_q.busy ##1 s_q.busy)
    else $error("load not started");
  chk_clk_idle_low: assert property (@(posedge clk_sys) disable iff (!nrst)
    spi_sel_n |-> !spi_clk_out)
    else $error("serial clock not idle low");
  chk_stretch_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    pri_stretch_req && s_q.en |=> pri_scl_hold)
    else $error("stretch not applied");

endmodule // bcl_boot_config

// ===== bench/bcl_flash_model.sv
`timescale 1ns/1ns
module bcl_flash_model (
  input  wire logic        spi_clk_out,
  input  wire logic        spi_sel_n,
  input  wire logic        spi_data_out,
  input  wire logic        strap_level,
  output wire logic        spi_data_in,
  output logic [31:0]      cmd_word
);
  int         cnt;
  logic [7:0] cur;
  logic       drv;

  function automatic logic [7:0] byte_at(input logic [15:0] a);
    return 8'h3c + a[7:0] * 8'h25;
  endfunction

  initial begin
    cnt      = 0;
    cmd_word = 32'h00000000;
    drv      = 1'b0;
  end

  // ----------------------------------------------------------------------
  // serial side, any clock up to 12 MHz, 64 kB of storage
  // ----------------------------------------------------------------------
  always @(negedge spi_sel_n) begin
    cnt      = 0;
    cmd_word = 32'h00000000;
  end

  always @(posedge spi_clk_out) begin
    if (!spi_sel_n) begin
      if (cnt < 32) cmd_word = {cmd_word[30:0], spi_data_out};
      cnt = cnt + 1;
    end
  end

  // data out on falling edge, junk that toggles before the data phase
  always @(negedge spi_clk_out) begin
    if (!spi_sel_n) begin
      if (cnt >= 32) begin
        cur = byte_at(16'((cnt - 32) / 8) + cmd_word[15:0]);
        drv = cur[7 - ((cnt - 32) % 8)];
      end else begin
        drv = ~drv;
      end
    end
  end

  // deselected: the strap resistor sets the level
  assign spi_data_in = spi_sel_n ? strap_level : drv;
endmodule // bcl_flash_model

// ===== bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import bcl_pkg::*;
  localparam int LB = 2;
  logic       clk_sys = 1'b0;
  logic       lclk    = 1'b0;
  logic       nrst    = 1'b0;
  logic [6:0] adr_s   = 7'h00;
  logic [6:0] div_s   = 7'h00;
  logic       sup     = 1'b0;
  logic       hcd     = 1'b0;
  logic       preq    = 1'b0;
  logic       sreq    = 1'b0;
  logic       din     = 1'b1;
  logic [6:0] pm      = 7'h00;
  logic [6:0] po      = 7'h00;
  logic       miso;
  logic       sclk;
  logic       sel_n;
  logic       mosi;
  bcl_addr_t  host_addr;
  logic       ports_enable;
  bcl_boot_t  boot_mode;
  logic       load_busy;
  logic       load_done;
  logic [7:0] load_byte;
  logic       load_byte_valid;
  logic       pri_scl_hold;
  logic       sec_scl_hold;
  logic [31:0] cmd_word;
  logic [7:0] got[$];
  int         bad_count = 0;
  int         compares  = 0;
  int         cyc       = 0;

  always #50 clk_sys = ~clk_sys;
  initial begin
    #7;
    forever #24 lclk = ~lclk;
  end

  bcl_boot_config #(.LOAD_BYTES(LB)) bcl_boot_config_inst (
    .clk_sys(clk_sys), .nrst(nrst), .address_strap_input(adr_s),
    .boot_strap_divider_input(div_s), .external_3v3_supply(sup),
    .pri_addr_mask(pm), .pri_addr_override(po),
    .sec_addr_mask({pm[3:0], pm[6:4]}), .sec_addr_override(~po),
    .host_config_done(hcd), .pri_stretch_req(preq),
    .sec_stretch_req(sreq), .spi_clk_link(lclk), .spi_data_in(miso),
    .spi_clk_out(sclk), .spi_sel_n(sel_n), .spi_data_out(mosi),
    .host_addr(host_addr), .ports_enable(ports_enable),
    .boot_mode(boot_mode), .load_busy(load_busy), .load_done(load_done),
    .load_byte(load_byte), .load_byte_valid(load_byte_valid),
    .pri_scl_hold(pri_scl_hold), .sec_scl_hold(sec_scl_hold));

  bcl_flash_model bcl_flash_model_inst (
    .spi_clk_out(sclk), .spi_sel_n(sel_n), .spi_data_out(mosi),
    .strap_level(din), .spi_data_in(miso), .cmd_word(cmd_word));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] flash_byte(input int i);
    return 8'h3c + 8'(i) * 8'h25;
  endfunction

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      print_verdict();
    end
  end

  always @(posedge clk_sys) begin
    if (load_byte_valid === 1'b1) got.push_back(load_byte);
    if (nrst && sel_n === 1'b1) check(sclk, 0);
  end

  task automatic wait_hi(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
  endtask

  // one boot with given straps and the expected decode
  task automatic run_case(input logic [6:0] adr, input logic [2:0] code,
                          input logic dl, input logic [6:0] div,
                          input bcl_db_t db, input bcl_cf_t cf);
    logic [6:0] pa;
    logic [6:0] sm;
    @(negedge clk_sys);
    nrst  = 1'b0;
    adr_s = adr;
    div_s = div;
    din   = dl;
    sup   = 1'b0;
    hcd   = 1'b0;
    repeat (3) @(negedge clk_sys);
    nrst = 1'b1;
    got.delete();
    repeat (40) @(negedge clk_sys);
    check(boot_mode, {db, cf});
    if (db inside {BCL_DB_NO_RESPONSE, BCL_DB_WAIT_INT, BCL_DB_WAIT_EXT})
      check({load_busy, sel_n, ports_enable}, 3'h2);
    sup = 1'b1;
    if (cf == BCL_CF_INFINITE) begin
      wait_hi(ports_enable, 2000);
      repeat (30) @(negedge clk_sys);
      check({load_done, ports_enable, load_busy}, 3'h2);
      hcd = 1'b1;
    end
    wait_hi(load_done, 2000);
    check(load_done, 1);
    wait_hi(ports_enable, 200);
    pa = {BCL_PRI_ADDR_HI, code};
    sm = {pm[3:0], pm[6:4]};
    check(host_addr, {(pm & po) | (~pm & pa),
                      (sm & ~po) | (~sm & BCL_SEC_ADDR)});
    check(cmd_word, 32'h03000000);
    check(got.size(), LB);
    foreach (got[i]) check(got[i], flash_byte(i));
    adr_s = ~adr;
    div_s = ~div;
    din   = ~dl;
    repeat (20) @(negedge clk_sys);
    check(boot_mode, {db, cf});
    $display("test done: strap %h/%h din %b", adr, div, dl);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    run_case(7'h00, 3'h0, 1, 7'h05, BCL_DB_NO_RESPONSE, BCL_CF_SAFE);
    run_case(7'h09, 3'h0, 1, 7'h19, BCL_DB_WAIT_INT, BCL_CF_SAFE);
    run_case(7'h0a, 3'h1, 1, 7'h22, BCL_DB_HOST_INT, BCL_CF_INFINITE);
    run_case(7'h26, 3'h1, 1, 7'h2c, BCL_DB_WAIT_EXT, BCL_CF_SAFE);
    run_case(7'h27, 3'h2, 1, 7'h36, BCL_DB_HOST_EXT, BCL_CF_INFINITE);
    run_case(7'h4a, 3'h2, 1, 7'h50, BCL_DB_NO_WAIT, BCL_CF_SAFE);
    run_case(7'h4b, 3'h3, 0, 7'h03, BCL_DB_NO_RESPONSE, BCL_CF_CONFIG1);
    run_case(7'h64, 3'h3, 0, 7'h0f, BCL_DB_NO_RESPONSE, BCL_CF_CONFIG1);
    run_case(7'h1e, 3'h1, 0, 7'h19, BCL_DB_NO_RESPONSE, BCL_CF_CONFIG2);
    run_case(7'h32, 3'h2, 0, 7'h22, BCL_DB_HOST_INT, BCL_CF_INFINITE);
    run_case(7'h05, 3'h0, 0, 7'h2c, BCL_DB_NO_WAIT, BCL_CF_CONFIG3);
    run_case(7'h50, 3'h3, 0, 7'h36, BCL_DB_HOST_EXT, BCL_CF_INFINITE);
    run_case(7'h14, 3'h1, 0, 7'h40, BCL_DB_NO_RESPONSE, BCL_CF_CONFIG4);
    run_case(7'h3c, 3'h2, 0, 7'h4a, BCL_DB_NO_WAIT, BCL_CF_SAFE);
    run_case(7'h60, 3'h3, 0, 7'h54, BCL_DB_NO_RESPONSE, BCL_CF_SAFE);
    pm = 7'h0f;
    po = 7'h05;
    run_case(7'h2a, 3'h2, 0, 7'h5f, BCL_DB_NO_WAIT, BCL_CF_CONFIG5);
    // primary then secondary stretch request sets only the matching hold
    preq = 1'b1;
    repeat (4) @(negedge clk_sys);
    check({pri_scl_hold, sec_scl_hold}, 2'h2);
    preq = 1'b0;
    sreq = 1'b1;
    repeat (4) @(negedge clk_sys);
    check({pri_scl_hold, sec_scl_hold}, 2'h1);
    $display("test done: stretch");
    print_verdict();
  end
endmodule // tb_top
